// ---- pcfg_consts.svh ----
// timing and field constants for the byte-wide parallel configuration port
// assumes inclusion by the interface and both ends
`ifndef PCFG_CONSTS_SVH
`define PCFG_CONSTS_SVH
`define PCFG_BYTE_W        8                  // data bus width
`define PCFG_CLK_PERIOD_NS 100                // clk period
`define PCFG_BUSY_GAP      4'h3               // device holds busy every Nth accept
`define PCFG_CNT_W         4                  // width of small counters
`define PCFG_STREAM_LEN    16'h0010           // bytes in a full bitstream
`define PCFG_LEN_W         16                 // width of stream length
`define PCFG_RB_SEED       8'hA5              // first readback byte
`define PCFG_RB_STEP       8'h01              // readback byte step
`define PCFG_MEM_DEPTH     16                 // host stream memory depth
`define PCFG_MEM_AW        4                  // host stream memory address width
`endif

// ---- pcfg_pkg.sv ----
// types shared by both ends of the parallel configuration port
// assumes pcfg_consts.svh for widths
`include "pcfg_consts.svh"
package pcfg_pkg;
   typedef logic [`PCFG_BYTE_W-1:0] byte_t;  // index 7 is the msb line
   typedef enum logic [1:0] {DevWait, DevLoad, DevDone, DevAbort} dev_state_t;
   typedef enum logic [1:0] {HostIdle, HostWrite, HostRead, HostEnd} host_state_t;
endpackage

// ---- pcfg_if.sv ----
// link between device end and host end of the configuration port
// assumes one clock; resolves two-way pins from the enables
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_consts.svh"
interface pcfg_if;
   // data bus: host and device each with in, out, enable
   logic [`PCFG_BYTE_W-1:0] dataHost;
   logic                    dataHostOe;
   logic [`PCFG_BYTE_W-1:0] dataDev;
   logic                    dataDevOe;
   wire  [`PCFG_BYTE_W-1:0] dataBus;
   // control driven by host
   logic                    portSelectN;
   logic                    writeNotReadN;
   logic                    programResetN;
   // status driven by device; busy is three-state
   logic                    busyOut;
   logic                    busyOe;
   wire                     busy;
   logic                    initReadyN;
   logic                    done;
   // wire resolution, float reads as zero
   assign dataBus = dataHostOe ? dataHost : (dataDevOe ? dataDev : '0);
   assign busy    = busyOe & busyOut;
   modport device (input dataBus, output dataDev, output dataDevOe, input portSelectN,
      input writeNotReadN, input programResetN, output busyOut, output busyOe,
      output initReadyN, output done);
   modport host (input dataBus, output dataHost, output dataHostOe, output portSelectN,
      output writeNotReadN, output programResetN, input busy, input initReadyN,
      input done);
endinterface
`default_nettype wire

// ---- pcfg_byte_order.sv ----
// bit order helper: line 0 of the bus carries the byte's msb
// assumes purely combinational use by either end
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_consts.svh"
module pcfg_byte_order
(
   // byte as stored, msb at index 7
   input  wire logic [`PCFG_BYTE_W-1:0] byteIn,
   // byte as on the bus lines, msb on line 0
   output logic      [`PCFG_BYTE_W-1:0] linesOut
);
   // plain mirror; mirroring is its own inverse so one helper serves both ways
   genvar i;
   generate
      for (i = 0; i < `PCFG_BYTE_W; i++)
      begin : g_mirror
         assign linesOut[i] = byteIn[`PCFG_BYTE_W-1-i];
      end
   endgenerate
endmodule
`default_nettype wire

// ---- pcfg_device.sv ----
// device end of the byte-wide slave configuration and readback port
// assumes clk is the config clock from the host, inputs synchronous to it
// assumes the host holds each byte until an accepting edge
// limitation: busy floats one edge after a deselect, its enable is registered
//
// Functional notes
// - eight-bit two-way data bus both directions
// - line zero carries each byte's msb
// - select low writes, high reads
// - deselected port neither samples nor drives
// - not busy, selected write edge captures byte
// - busy edge discards byte, host repeats it
// - busy floats whenever port is deselected
// - host watches busy only above 66 MHz; this host watches it on every edge at any rate
// - shared-load chains ignore busy, slower clock
// - config clock input times all port logic
// - one byte accepted per clock edge
// - port idle until init ready rises
// - select order free; write held throughout
// - early read select aborts; program reset recovers
// - deselected edges ignored, no data expected
// - read level while selected mid-load aborts
// - host returns write low before edge
// - parallel chain uses separate selects
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_consts.svh"
module pcfg_device
(
   // clock and reset; clk is the config clock
   input  wire logic                    clk,
   input  wire logic                    reset,
   // link to host
   pcfg_if.device                       link,
   // user side: accepted bytes
   output logic      [`PCFG_BYTE_W-1:0] cfgByte,
   output logic                         cfgValid,
   // user side: status
   output logic                         cfgDone,
   output logic                         cfgAbort,
   output logic      [`PCFG_LEN_W-1:0]  cfgCount
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      pcfg_pkg::dev_state_t    st;       // load phase
      logic                    initN;    // init ready, low while resetting
      logic [`PCFG_CNT_W-1:0]  gap;      // accepts since last busy
      logic                    busyO;    // busy level
      logic                    busyE;    // busy drive enable
      pcfg_pkg::byte_t         rbByte;   // next readback byte
      logic                    dOe;      // data drive enable
      pcfg_pkg::byte_t         dOut;     // readback on bus
      pcfg_pkg::byte_t         capB;     // captured byte
      logic                    capV;     // capture pulse
      logic [`PCFG_LEN_W-1:0]  cnt;      // bytes taken
      logic                    doneF;    // load complete flag
      logic                    abortF;   // load aborted flag
   } dev_t;
   dev_t s_q;                            // registered state
   dev_t s_d;                            // next state
   ////////////////////////////////////////////////////////////////////////////
   // bit order conversion for both directions
   pcfg_pkg::byte_t busByte;             // bus lines turned to a byte
   pcfg_pkg::byte_t rbLines;             // readback byte as lines
   pcfg_byte_order u_in  (.byteIn(link.dataBus), .linesOut(busByte));
   pcfg_byte_order u_out (.byteIn(s_q.rbByte),   .linesOut(rbLines));
   ////////////////////////////////////////////////////////////////////////////
   // bus decode for the wait state; the read decode is shared with the done state
   // selected write edge: both strobes low
   function automatic logic wrEdge(input logic selN, input logic rwN);
      return !selN && !rwN;
   endfunction
   // selected read edge: select low, direction high
   function automatic logic rdEdge(input logic selN, input logic rwN);
      return !selN && rwN;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      s_d      = s_q;
      s_d.capV = 1'b0;
      s_d.dOe  = 1'b0;
      s_d.initN = 1'b1;                  // init done one edge after reset
      // busy enable follows the select one edge late, so busy is still driven one edge past a deselect
      s_d.busyE = ~link.portSelectN;
      unique case (s_q.st)
         pcfg_pkg::DevWait:
         begin
            // inactive until init ready is high
            // first byte counts toward the throttle like any other
            if (s_q.initN && wrEdge(link.portSelectN, link.writeNotReadN))
            begin
               s_d.st = pcfg_pkg::DevLoad;
               s_d.capB = busByte;
               s_d.capV = 1'b1;
               s_d.cnt  = s_q.cnt + 1'b1;
               s_d.gap  = s_q.gap + 1'b1;
            end
            else if (s_q.initN && rdEdge(link.portSelectN, link.writeNotReadN))
            begin
               // idle readback, one byte per edge
               s_d.dOe    = 1'b1;
               s_d.dOut   = rbLines;
               s_d.rbByte = s_q.rbByte + `PCFG_RB_STEP;
            end
         end
         pcfg_pkg::DevLoad:
         begin
            if (link.portSelectN)
            begin
               // deselected: edge ignored, nothing sampled
               s_d.st = s_q.st;
            end
            else if (link.writeNotReadN)
            begin
               // read level mid-load: final until program reset
               s_d.st = pcfg_pkg::DevAbort;
            end
            else if (s_q.busyO && s_q.busyE)
            begin
               // busy as the host saw it: byte discarded, throttle released;
               // a throttle held over a deselect waits until it is shown
               s_d.busyO = 1'b0;
            end
            else
            begin
               // accepting edge: one byte per edge, handed to the user
               s_d.capB = busByte;
               s_d.capV = 1'b1;
               s_d.cnt  = s_q.cnt + 1'b1;
               s_d.gap  = s_q.gap + 1'b1;
               if (s_q.gap + 1'b1 == `PCFG_BUSY_GAP)
               begin
                  s_d.busyO = 1'b1;      // periodic throttle
                  s_d.gap   = '0;
               end
               if (s_q.cnt + 1'b1 == `PCFG_STREAM_LEN)
               begin
                  s_d.st = pcfg_pkg::DevDone;
               end
            end
         end
         pcfg_pkg::DevDone:
         begin
            // configured: readback still served while selected for read
            s_d.busyO = 1'b0;
            // write edges after completion are ignored
            if (rdEdge(link.portSelectN, link.writeNotReadN))
            begin
               s_d.dOe    = 1'b1;
               s_d.dOut   = rbLines;
               s_d.rbByte = s_q.rbByte + `PCFG_RB_STEP;
            end
         end
         pcfg_pkg::DevAbort:
         begin
            s_d.busyO = 1'b0;            // stays here until program reset
         end
      endcase
      // program reset restarts the whole load
      // a sync clear, so a pulse mid-load leaves no partial state
      if (!link.programResetN)
      begin
         s_d       = '0;
         s_d.st    = pcfg_pkg::DevWait;
         s_d.rbByte = `PCFG_RB_SEED;
      end
      // status flags registered so the user outputs come from flip-flops
      s_d.doneF  = (s_d.st == pcfg_pkg::DevDone);
      s_d.abortF = (s_d.st == pcfg_pkg::DevAbort);
   end
   ////////////////////////////////////////////////////////////////////////////
   // registers, all on the config clock
   // sync reset holds init ready low while it lasts
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_q        <= '0;
         s_q.st     <= pcfg_pkg::DevWait;
         s_q.rbByte <= `PCFG_RB_SEED;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   // link side; the data enable alone is also cut by the select, since
   // a registered enable would hold the bus one edge into a deselect
   assign link.dataDev    = s_q.dOut;
   assign link.dataDevOe  = s_q.dOe & ~link.portSelectN;
   assign link.busyOut    = s_q.busyO;
   assign link.busyOe     = s_q.busyE;
   assign link.initReadyN = s_q.initN;
   assign link.done       = s_q.doneF;
   // user side
   assign cfgByte  = s_q.capB;
   assign cfgValid = s_q.capV;
   assign cfgDone  = s_q.doneF;
   assign cfgAbort = s_q.abortF;
   assign cfgCount = s_q.cnt;
endmodule
`default_nettype wire

// ---- pcfg_host.sv ----
// host end: streams a stored bitstream into the device and reads back
// assumes clk is the same config clock given to the device
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_consts.svh"
module pcfg_host
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset,
   // link to device
   pcfg_if.host                         link,
   // user side: stream memory load
   input  wire logic                    memWe,
   input  wire logic [`PCFG_MEM_AW-1:0] memAddr,
   input  wire logic [`PCFG_BYTE_W-1:0] memData,
   // user side: commands, one-cycle pulses
   input  wire logic                    startLoad,
   input  wire logic                    startRead,
   input  wire logic                    stopRead,
   input  wire logic                    progPulse,
   // user side: status and readback
   output logic                         hostBusy,
   output logic      [`PCFG_BYTE_W-1:0] readByte,
   output logic                         readValid
);
   pcfg_pkg::byte_t mem [`PCFG_MEM_DEPTH];   // stream store
   typedef struct packed {
      pcfg_pkg::host_state_t  st;        // phase
      logic [`PCFG_MEM_AW-1:0] ptr;      // next byte
      logic                   sel;       // select asserted
      logic                   wr;        // write selected
      logic                   oe;        // data drive
      logic                   prog;      // program reset active
      pcfg_pkg::byte_t        rd;        // readback byte
      logic                   rdV;       // readback pulse
      logic                   arm;       // bus turned round for readback
   } host_t;
   host_t h_q;                           // registered state
   host_t h_d;                           // next state
   pcfg_pkg::byte_t rdByte;              // bus lines as byte
   pcfg_pkg::byte_t outLines;            // stored byte as lines
   pcfg_byte_order u_in  (.byteIn(link.dataBus), .linesOut(rdByte));
   pcfg_byte_order u_out (.byteIn(mem[h_q.ptr]), .linesOut(outLines));
   ////////////////////////////////////////////////////////////////////////////
   // stream store write port
   always_ff @(posedge clk)
   begin
      if (memWe)
      begin
         mem[memAddr] <= memData;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // next state; busy is watched every edge, safe at any rate
   always_comb
   begin
      h_d      = h_q;
      h_d.rdV  = 1'b0;
      h_d.prog = progPulse;
      unique case (h_q.st)
         pcfg_pkg::HostIdle:
         begin
            if (startLoad)
            begin
               h_d.st = pcfg_pkg::HostWrite;
               h_d.sel = 1'b1;
               h_d.wr  = 1'b1;
               h_d.oe  = 1'b1;
               h_d.ptr = '0;
            end
            else if (startRead)
            begin
               h_d.st = pcfg_pkg::HostRead;
               h_d.sel = 1'b1;
               h_d.wr  = 1'b0;
            end
         end
         pcfg_pkg::HostWrite:
         begin
            // advance only on an edge the device took: init high, not busy
            if (link.initReadyN && !link.busy)
            begin
               h_d.ptr = h_q.ptr + 1'b1;
               if (int'(h_q.ptr) == `PCFG_MEM_DEPTH - 1)
               begin
                  h_d.st = pcfg_pkg::HostEnd;
               end
            end
         end
         pcfg_pkg::HostRead:
         begin
            // first edge after selecting only turns the bus round;
            // the device drives its first byte from that edge on
            h_d.rd  = rdByte;
            h_d.rdV = h_q.arm;
            h_d.arm = 1'b1;
            if (stopRead)
            begin
               h_d.st = pcfg_pkg::HostEnd;
            end
         end
         pcfg_pkg::HostEnd:
         begin
            // deselect with the write strobe, one edge after leaving write; deselected, so no abort
            h_d.sel = 1'b0;
            h_d.oe  = 1'b0;
            h_d.wr  = 1'b0;
            h_d.arm = 1'b0;
            h_d.st  = pcfg_pkg::HostIdle;
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         h_q    <= '0;
         h_q.st <= pcfg_pkg::HostIdle;
      end
      else
      begin
         h_q <= h_d;
      end
   end
   // outputs; data driven from the stored byte at the pointer
   assign link.dataHost      = outLines;
   assign link.dataHostOe    = h_q.oe;
   assign link.portSelectN   = ~h_q.sel;
   assign link.writeNotReadN = ~h_q.wr;
   assign link.programResetN = ~h_q.prog;
   assign hostBusy  = (h_q.st != pcfg_pkg::HostIdle);
   assign readByte  = h_q.rd;
   assign readValid = h_q.rdV;
endmodule
`default_nettype wire

// ---- pcfg_link_properties.sv ----
// link checks between host end and device end
// assumes one clock and sync active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_consts.svh"
module pcfg_link_properties
(
   // clock and reset
   input wire logic                    clk,
   input wire logic                    reset,
   // data bus parts
   input wire logic [`PCFG_BYTE_W-1:0] dataBus,
   input wire logic [`PCFG_BYTE_W-1:0] dataDev,
   input wire logic                    dataDevOe,
   input wire logic                    dataHostOe,
   // control and status
   input wire logic                    portSelectN,
   input wire logic                    writeNotReadN,
   input wire logic                    programResetN,
   input wire logic                    busyOut,
   input wire logic                    busyOe,
   input wire logic                    initReadyN,
   input wire logic                    done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // lines back to stored order; line 0 is the msb
   function automatic logic [7:0] unLine(input logic [7:0] l);
      return {<<{l}};
   endfunction
   // one edge of slack: enables may be registered
   float_busy_a: assert property (portSelectN [*2] |-> !busyOe)
      else $error("busy driven while deselected");
   desel_quiet_a: assert property (portSelectN [*2] |-> !dataDevOe)
      else $error("data driven while deselected");
   write_dir_a: assert property ((!portSelectN && !writeNotReadN) [*2] |-> !dataDevOe)
      else $error("device drives during write");
   no_clash_a: assert property (!(dataDevOe && dataHostOe))
      else $error("both ends drive the bus");
   busy_pulse_a: assert property (busyOe && busyOut |=> !(busyOe && busyOut))
      else $error("busy longer than one edge");
   byte_repeat_a: assert property (busyOe && busyOut && !writeNotReadN |=>
      dataBus == $past(dataBus))
      else $error("byte not repeated after busy");
   init_rise_a: assert property ($fell(reset) |=> initReadyN)
      else $error("init ready late");
   done_hold_a: assert property (done && programResetN |=> done)
      else $error("done dropped");
   prog_clear_a: assert property (!programResetN |=> !done)
      else $error("done survives program reset");
   rb_step_a: assert property (dataDevOe && $past(dataDevOe) |->
      unLine(dataDev) == unLine($past(dataDev)) + `PCFG_RB_STEP)
      else $error("readback step wrong");
   // main scenarios reached
   busy_c: cover property (busyOe && busyOut);
   done_c: cover property (done);
   read_c: cover property (dataDevOe);
   prog_c: cover property (!programResetN);
endmodule
`default_nettype wire

// ---- slave_parallel_config_port_tb_top.sv ----
// bench: host end streams into device end; a second link is broken on purpose
// assumes design files and link checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_consts.svh"
module slave_parallel_config_port_tb_top;
   logic clk = 1'b0, reset = 1'b1;                       // clock, sync reset
   logic memWe = 1'b0, startLoad = 1'b0, startRead = 1'b0;
   logic stopRead = 1'b0, progPulse = 1'b0;              // host commands
   logic [3:0] memAddr = '0;                             // stream memory address
   logic [7:0] memData = '0, cfgByte, readByte, fByte;
   logic [7:0] rbExp = `PCFG_RB_SEED;                    // next readback byte
   logic [15:0] cfgCount, fCount;
   logic cfgValid, cfgDone, cfgAbort, hostBusy, readValid, fDone, fAbort;
   logic [7:0] expQ[$];                                  // bytes noted by the driver
   logic [7:0] fb[3];                                    // fault link bytes
   int n_errors = 0, checks = 0, busyCnt = 0, k, g, b0, sd;
   pcfg_if linkMain ();
   pcfg_if linkFault ();
   pcfg_device pcfg_device_inst (.clk(clk), .reset(reset), .link(linkMain),
      .cfgByte(cfgByte), .cfgValid(cfgValid), .cfgDone(cfgDone), .cfgAbort(cfgAbort),
      .cfgCount(cfgCount));
   pcfg_device pcfg_device_inst2 (.clk(clk), .reset(reset), .link(linkFault),
      .cfgByte(fByte), .cfgValid(), .cfgDone(fDone), .cfgAbort(fAbort), .cfgCount(fCount));
   pcfg_host pcfg_host_inst (.clk(clk), .reset(reset), .link(linkMain), .memWe(memWe),
      .memAddr(memAddr), .memData(memData), .startLoad(startLoad), .startRead(startRead),
      .stopRead(stopRead), .progPulse(progPulse), .hostBusy(hostBusy),
      .readByte(readByte), .readValid(readValid));
   pcfg_link_properties pcfg_link_properties_inst (.clk(clk), .reset(reset),
      .dataBus(linkMain.dataBus), .dataDev(linkMain.dataDev),
      .dataDevOe(linkMain.dataDevOe), .dataHostOe(linkMain.dataHostOe),
      .portSelectN(linkMain.portSelectN), .writeNotReadN(linkMain.writeNotReadN),
      .programResetN(linkMain.programResetN), .busyOut(linkMain.busyOut),
      .busyOe(linkMain.busyOe), .initReadyN(linkMain.initReadyN), .done(linkMain.done));
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   // stored byte to bus lines, msb on line 0
   function automatic logic [7:0] rev(input logic [7:0] b);
      return {<<{b}};
   endfunction
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", what, e, s);
      end
   endtask
   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // bounded wait for the host to go idle; a hang ends the run
   task automatic waitIdle();
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (hostBusy !== 1'b0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 400)
      begin
         chk("hostBusy", 16'h0000, 16'h0001);
         conclude();
      end
   endtask
   // fill stream memory with random bytes, note them, start a load
   task automatic loadStream();
      logic [7:0] b;
      for (int a = 0; a < 16; a++)
      begin
         @(posedge clk);
         b = 8'($urandom);
         memWe <= 1'b1;
         memAddr <= a[3:0];
         memData <= b;
         expQ.push_back(b);
      end
      @(posedge clk);
      memWe <= 1'b0;
      startLoad <= 1'b1;
      @(posedge clk);
      startLoad <= 1'b0;
      waitIdle();
      chk("cfgCount", `PCFG_STREAM_LEN, cfgCount);
      chk("cfgDone", 16'h0001, cfgDone);
      chk("leftover", 16'h0000, 16'(expQ.size()));
   endtask
   // watcher: takes the oldest note when a result appears
   always @(posedge clk)
   begin
      if (cfgValid === 1'b1)
         chk("cfgByte", expQ.size() ? expQ.pop_front() : 8'hXX, cfgByte);
      if (readValid === 1'b1)
      begin
         chk("readByte", rbExp, readByte);
         rbExp <= rbExp + `PCFG_RB_STEP;
      end
      if (linkMain.busy === 1'b1) busyCnt <= busyCnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sd = $urandom(32'hCAEC0206);
      foreach (fb[i]) fb[i] = 8'($urandom);
      // fault link selected for write before init ready
      linkFault.programResetN = 1'b1;
      linkFault.portSelectN = 1'b0;
      linkFault.writeNotReadN = 1'b0;
      linkFault.dataHostOe = 1'b1;
      linkFault.dataHost = rev(fb[0]);
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      k = 0;
      g = 0;
      while (k < 3 && g < 50)
      begin
         @(posedge clk);
         g++;
         if (linkFault.initReadyN === 1'b1 && linkFault.busy !== 1'b1) k++;
         linkFault.dataHost <= rev(fb[k % 3]);
      end
      chk("fault bytes", 16'h0003, k[15:0]);
      if (k < 3)
      begin
         conclude();
      end
      linkFault.portSelectN <= 1'b1;
      repeat (4) @(posedge clk) linkFault.dataHost <= 8'($urandom);
      @(negedge clk);
      chk("fCount", 16'h0003, fCount);
      chk("fByte", fb[2], fByte);
      @(posedge clk);
      linkFault.portSelectN <= 1'b0;
      linkFault.writeNotReadN <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("fAbort", 16'h0001, fAbort);
      @(posedge clk);
      linkFault.portSelectN <= 1'b1;
      linkFault.programResetN <= 1'b0;
      @(posedge clk);
      linkFault.programResetN <= 1'b1;
      repeat (2) @(negedge clk);
      chk("fAbort cleared", 16'h0000, fAbort);
      // main link: full stream with busy every third byte
      b0 = busyCnt;
      loadStream();
      chk("busy pulses", 16'h0005, 16'(busyCnt - b0));
      @(posedge clk);
      startRead <= 1'b1;
      @(posedge clk);
      startRead <= 1'b0;
      repeat (8) @(posedge clk);
      stopRead <= 1'b1;
      @(posedge clk);
      stopRead <= 1'b0;
      waitIdle();
      chk("read seen", 16'h0001, rbExp !== `PCFG_RB_SEED);
      chk("no abort", 16'h0000, cfgAbort);
      // program reset then a second full stream
      @(posedge clk);
      progPulse <= 1'b1;
      @(posedge clk);
      progPulse <= 1'b0;
      repeat (3) @(negedge clk);
      chk("done cleared", 16'h0000, cfgDone);
      b0 = busyCnt;
      loadStream();
      chk("busy pulses 2", 16'h0005, 16'(busyCnt - b0));
      conclude();
   end
endmodule
`default_nettype wire
